//--- design/sfa_pkg.sv
// Shared constants and types of the serial port control block.
//
// Function
// - framed bit makes select pin frame sync
// - sync direction: 1 input, 0 output
// - sync polarity bit sets pulse active level
// - autodrive select pin in master, polarity bit
// - pulse width: whole character or one bit
// - pulse count code sets characters per pulse
// - bit clock from reference or bus clock
// - source and buffer bits writable only off
// - edge bit: pulse on or before bit
// - deep buffer bit enables multi-word buffering
// - module on bit enables whole peripheral
// - idle stop halts operation in idle
// - out disable releases serial data pin
// - audio width bits choose channel format
// - plain mode upper bit 32, lower 16
// - master sample phase: end or middle
// - slave samples mid; phase needs master first
// - output edge: trailing or leading transition
// - slave select enable uses low select
// - clock polarity sets idle level
// - audio mode forces clock polarity high
// - master enable selects master or slave
// - audio enable switches to audio operation
package sfa_pkg;
   localparam logic [7:0] SFA_OFS_CTRL = 8'h00;
   localparam logic [7:0] SFA_OFS_CTRL2 = 8'h04;
   localparam logic [7:0] SFA_OFS_STAT = 8'h08;
   localparam logic [7:0] SFA_OFS_DATA = 8'h0C;
   localparam logic [31:0] SFA_CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] SFA_CTRL_WMASK = 32'hFF83_BFE0;
   localparam int SFA_AUDIO_BIT = 7;
   localparam int SFA_ST_RXFULL = 0;
   localparam int SFA_ST_TXFULL = 1;
   localparam int SFA_ST_TXEMPTY = 3;
   localparam int SFA_ST_BUSY = 11;
   localparam int SFA_ST_CNT_LSB = 16;
   localparam logic [5:0] SFA_W8 = 6'h08;
   localparam logic [5:0] SFA_W16 = 6'h10;
   localparam logic [5:0] SFA_W32 = 6'h20;

   typedef struct packed {
      logic framed_mode_enable;
      logic frame_sync_direction;
      logic frame_sync_polarity;
      logic master_select_autodrive;
      logic frame_pulse_width;
      logic [2:0] frame_pulse_count;
      logic bitclock_source_select;
      logic [4:0] rsv_a;
      logic frame_edge_select;
      logic deep_buffer_enable;
      logic module_on;
      logic rsv_b;
      logic idle_stop;
      logic serial_out_disable;
      logic width_select_upper;
      logic width_select_lower;
      logic input_sample_phase;
      logic output_edge_select;
      logic slave_select_enable;
      logic clock_polarity;
      logic master_role_enable;
      logic [4:0] rsv_c;
   } sfa_ctrl_t;

   typedef enum logic [1:0] {
      SFA_IDLE = 2'b00,
      SFA_PRE = 2'b01,
      SFA_SHIFT = 2'b10
   } sfa_state_t;
endpackage

//--- design/sfa_port.sv
// Serial port with framed and audio modes, configured over APB.
`timescale 1ns/1ps
module sfa_port
   import sfa_pkg::*;
#(
   // Half bit period in ticks. The input synchroniser adds two cycles, so values below
   // three would sample the far side's data before its new bit has passed the flops.
   parameter int HALF_DIV = 4,
   parameter int DEPTH = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic idle_mode,
   input wire logic reference_clock,
   input wire logic sck_i,
   output logic sck_o,
   output logic sck_oe_n,
   input wire logic sdi_i,
   output logic serial_out_pin,
   output logic serial_out_oe_n,
   input wire logic select_pin_i,
   output logic select_pin_o,
   output logic select_pin_oe_n
);
   localparam int PW = $clog2(DEPTH);

   sfa_ctrl_t ctrl_q;
   logic audio_q;
   logic [31:0] prdata_q;
   logic pready_q, pslverr_q;
   logic [31:0] tx_mem [DEPTH];
   logic [PW-1:0] wr_q, rd_q;
   logic [PW:0] cnt_q;
   logic [31:0] rx_q;
   logic rx_full_q;
   sfa_state_t st_q;
   logic [31:0] tsh_q, rsh_q;
   logic [6:0] half_q;
   logic [7:0] div_q;
   logic [5:0] grp_q;
   logic first_q;
   logic sck_q, sck_oe_n_q, sdo_q, sdo_oe_n_q, sel_q, sel_oe_n_q;
   logic [2:0] ref_s, sck_s;
   logic [1:0] sel_s, sdi_s;

   // ----------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------
   logic run, master, framed, ckp_eff, smp_eff, tick, ev, ev_lead;
   logic chg, samp, acc, wr, rd, full, push, start, done, sel_act;
   logic slave_go, sync_in;
   logic [5:0] wbits;
   logic [PW:0] cap;
   logic [5:0] grp_len;

   assign run = ctrl_q.module_on && !(ctrl_q.idle_stop && idle_mode);
   assign master = ctrl_q.master_role_enable;
   assign framed = ctrl_q.framed_mode_enable;
   assign ckp_eff = ctrl_q.clock_polarity | audio_q;
   assign smp_eff = ctrl_q.input_sample_phase & master;
   assign cap = ctrl_q.deep_buffer_enable ? (PW+1)'(DEPTH) : (PW+1)'(1);
   assign full = cnt_q >= cap;
   assign grp_len = 6'(6'h01 << ctrl_q.frame_pulse_count);

   always_comb begin
      if (audio_q) begin
         wbits = (ctrl_q.width_select_upper | ctrl_q.width_select_lower) ? SFA_W32 : SFA_W16;
      end else if (ctrl_q.width_select_upper) begin
         wbits = SFA_W32;
      end else if (ctrl_q.width_select_lower) begin
         wbits = SFA_W16;
      end else begin
         wbits = SFA_W8;
      end
   end

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_s <= 3'h0;
         sck_s <= 3'h0;
         sel_s <= 2'h3;
         sdi_s <= 2'h0;
      end else begin
         ref_s <= {ref_s[1:0], reference_clock};
         sck_s <= {sck_s[1:0], sck_i};
         sel_s <= {sel_s[0], select_pin_i};
         sdi_s <= {sdi_s[0], sdi_i};
      end
   end

   // ----------------------------------------------------------------
   // APB slave, one wait state
   // ----------------------------------------------------------------
   assign acc = psel && penable && pready_q;
   assign wr = acc && pwrite && !pslverr_q;
   assign rd = acc && !pwrite && paddr == SFA_OFS_DATA;
   assign push = wr && paddr == SFA_OFS_DATA && !full;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= psel && penable && !pready_q;
         pslverr_q <= psel && penable && !pready_q && paddr != SFA_OFS_CTRL
            && paddr != SFA_OFS_CTRL2 && paddr != SFA_OFS_STAT && paddr != SFA_OFS_DATA;
         prdata_q <= 32'h0000_0000;
         if (psel && penable && !pready_q && !pwrite) begin
            case (paddr)
               SFA_OFS_CTRL: prdata_q <= ctrl_q;
               SFA_OFS_CTRL2: prdata_q[SFA_AUDIO_BIT] <= audio_q;
               SFA_OFS_STAT: begin
                  prdata_q[SFA_ST_RXFULL] <= rx_full_q;
                  prdata_q[SFA_ST_TXFULL] <= full;
                  prdata_q[SFA_ST_TXEMPTY] <= cnt_q == '0;
                  prdata_q[SFA_ST_BUSY] <= st_q != SFA_IDLE;
                  prdata_q[SFA_ST_CNT_LSB +: PW+1] <= cnt_q;
               end
               SFA_OFS_DATA: prdata_q <= rx_q;
               default: prdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= SFA_CTRL_RST;
         audio_q <= 1'b0;
      end else if (wr && paddr == SFA_OFS_CTRL) begin
         ctrl_q <= pwdata & SFA_CTRL_WMASK;
         if (ctrl_q.module_on) begin
            ctrl_q.bitclock_source_select <= ctrl_q.bitclock_source_select;
            ctrl_q.deep_buffer_enable <= ctrl_q.deep_buffer_enable;
         end
         if (!ctrl_q.master_role_enable) begin
            ctrl_q.input_sample_phase <= 1'b0;
         end
      end else if (wr && paddr == SFA_OFS_CTRL2 && !ctrl_q.module_on) begin
         audio_q <= pwdata[SFA_AUDIO_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Transmit buffer and receive word
   // ----------------------------------------------------------------
   always_ff @(posedge pclk) begin
      if (push) begin
         tx_mem[wr_q] <= pwdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else if (!ctrl_q.module_on) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= PW'(wr_q + 1'b1);
         end
         if (start && cnt_q != '0) begin
            rd_q <= PW'(rd_q + 1'b1);
         end
         cnt_q <= (PW+1)'(cnt_q + push - (start && cnt_q != '0));
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_q <= 32'h0000_0000;
         rx_full_q <= 1'b0;
      end else if (done) begin
         // When the last bit is sampled on the edge that ends the word, fold it in here.
         rx_q <= samp ? {rsh_q[30:0], sdi_s[1]} : rsh_q;
         rx_full_q <= 1'b1;
      end else if (rd) begin
         rx_full_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Bit clock generation and edge events
   // ----------------------------------------------------------------
   assign tick = ctrl_q.bitclock_source_select ? (ref_s[1] && !ref_s[2]) : 1'b1;
   assign sync_in = sel_s[1] == ctrl_q.frame_sync_polarity;
   assign slave_go = framed ? (ctrl_q.frame_sync_direction && sync_in)
      : (!ctrl_q.slave_select_enable || !sel_s[1]);
   assign start = run && st_q == SFA_IDLE && (master ? cnt_q != '0 : slave_go);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= 8'h00;
      end else if (!run || st_q == SFA_IDLE) begin
         div_q <= 8'h00;
      end else if (tick) begin
         div_q <= (div_q >= 8'(HALF_DIV - 1)) ? 8'h00 : 8'(div_q + 1'b1);
      end
   end

   always_comb begin
      if (master) begin
         ev = run && st_q != SFA_IDLE && tick && div_q >= 8'(HALF_DIV - 1);
         ev_lead = sck_q == ckp_eff;
      end else begin
         ev = run && st_q != SFA_IDLE && sck_s[1] != sck_s[2];
         ev_lead = sck_s[2] == ckp_eff;
      end
   end

   assign chg = ev && st_q == SFA_SHIFT
      && (ctrl_q.output_edge_select ? !ev_lead : ev_lead);
   assign samp = ev && st_q == SFA_SHIFT
      && (ctrl_q.output_edge_select ? ev_lead : !ev_lead) == !smp_eff;
   assign done = ev && st_q == SFA_SHIFT && half_q == 7'({wbits, 1'b0} - 1'b1);

   // ----------------------------------------------------------------
   // Shift sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= SFA_IDLE;
         half_q <= 7'h00;
         tsh_q <= 32'h0000_0000;
         rsh_q <= 32'h0000_0000;
         first_q <= 1'b0;
         grp_q <= 6'h00;
         sck_q <= 1'b0;
      end else if (!run) begin
         st_q <= SFA_IDLE;
         half_q <= 7'h00;
         first_q <= 1'b0;
         grp_q <= 6'h00;
         sck_q <= ckp_eff;
      end else begin
         if (st_q == SFA_IDLE) begin
            sck_q <= ckp_eff;
         end else if (master && ev) begin
            sck_q <= !sck_q;
         end
         if (samp) begin
            rsh_q <= {rsh_q[30:0], sdi_s[1]};
         end
         case (st_q)
            SFA_IDLE: begin
               if (start) begin
                  tsh_q <= (cnt_q != '0) ? tx_mem[rd_q] << (SFA_W32 - wbits) : 32'h0000_0000;
                  // Clearing the receive shifter keeps short words right aligned.
                  rsh_q <= 32'h0000_0000;
                  first_q <= 1'b1;
                  half_q <= 7'h00;
                  st_q <= (master && framed && grp_q == 6'h00
                     && !ctrl_q.frame_edge_select) ? SFA_PRE : SFA_SHIFT;
               end
            end
            SFA_PRE: begin
               if (ev) begin
                  half_q <= 7'(half_q + 1'b1);
                  if (half_q[0]) begin
                     half_q <= 7'h00;
                     st_q <= SFA_SHIFT;
                  end
               end
            end
            SFA_SHIFT: begin
               if (chg) begin
                  first_q <= 1'b0;
                  if (!first_q || ctrl_q.output_edge_select) begin
                     tsh_q <= {tsh_q[30:0], 1'b0};
                  end
               end
               if (ev) begin
                  half_q <= 7'(half_q + 1'b1);
               end
               if (done) begin
                  st_q <= SFA_IDLE;
                  grp_q <= (6'(grp_q + 1'b1) >= grp_len) ? 6'h00 : 6'(grp_q + 1'b1);
               end
            end
            default: st_q <= SFA_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Pin drivers
   // ----------------------------------------------------------------
   always_comb begin
      sel_act = 1'b0;
      if (framed) begin
         sel_act = st_q == SFA_PRE || (st_q == SFA_SHIFT && grp_q == 6'h00
            && (ctrl_q.frame_pulse_width
            || (ctrl_q.frame_edge_select && half_q < 7'h02)));
      end else begin
         sel_act = st_q != SFA_IDLE;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_oe_n_q <= 1'b1;
         sdo_q <= 1'b0;
         sdo_oe_n_q <= 1'b1;
         sel_q <= 1'b1;
         sel_oe_n_q <= 1'b1;
      end else begin
         sck_oe_n_q <= !(ctrl_q.module_on && master);
         sdo_q <= tsh_q[31];
         sdo_oe_n_q <= !ctrl_q.module_on || ctrl_q.serial_out_disable;
         sel_q <= sel_act ? ctrl_q.frame_sync_polarity : !ctrl_q.frame_sync_polarity;
         sel_oe_n_q <= !(ctrl_q.module_on && (framed ? !ctrl_q.frame_sync_direction
            : (master && ctrl_q.master_select_autodrive)));
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign sck_o = sck_q;
   assign sck_oe_n = sck_oe_n_q;
   assign serial_out_pin = sdo_q;
   assign serial_out_oe_n = sdo_oe_n_q;
   assign select_pin_o = sel_q;
   assign select_pin_oe_n = sel_oe_n_q;
endmodule

//--- bench/sfa_port_monitor.sv
// Assertion checker for the serial port top.
`timescale 1ns/1ps
module sfa_port_monitor
   import sfa_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic sck_o,
   input wire logic sck_oe_n,
   input wire logic serial_out_oe_n,
   input wire logic select_pin_oe_n
);
   logic [31:0] sh_q;
   logic [31:0] sh_d;
   logic aud_q;
   logic [1:0] set_q;
   sfa_ctrl_t c;
   wire wr = psel && penable && pready && pwrite;
   wire cfg = paddr == SFA_OFS_CTRL || paddr == SFA_OFS_CTRL2;
   wire st = set_q == 2'd3;
   assign c = sh_q;
   // Shadow of the control word, so pin checks can wait until it settles.
   always_comb begin
      sh_d = pwdata & SFA_CTRL_WMASK;
      if (sh_q[15]) begin
         sh_d[23] = sh_q[23];
         sh_d[16] = sh_q[16];
      end
      sh_d[9] = sh_d[9] & sh_q[5];
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sh_q <= SFA_CTRL_RST;
         aud_q <= 1'b0;
         set_q <= 2'd0;
      end else begin
         if (wr && paddr == SFA_OFS_CTRL) sh_q <= sh_d;
         if (wr && paddr == SFA_OFS_CTRL2 && !sh_q[15]) aud_q <= pwdata[SFA_AUDIO_BIT];
         if (wr && cfg) set_q <= 2'd0;
         else if (!st) set_q <= set_q + 2'd1;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_ACCESS_WAIT: assert property ($rose(penable) && psel |=> pready)
      else $error("pready late");
   AST_PREADY_PULSE: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   AST_UNMAPPED: assert property (pready |-> pslverr == (paddr > 8'h0C || paddr[1:0] != 2'b00))
      else $error("pslverr wrong");
   AST_CTRL_READ: assert property (pready && !pwrite && paddr == SFA_OFS_CTRL |-> prdata == sh_q)
      else $error("control read wrong");
   AST_IDLE_LEVEL: assert property (st && !c.module_on |-> sck_o == (c.clock_polarity | aud_q))
      else $error("clock idle level wrong");
   AST_OFF_RELEASE: assert property (st && !c.module_on |-> sck_oe_n && serial_out_oe_n && select_pin_oe_n)
      else $error("pins driven while off");
   AST_ROLE_CLK: assert property (st && c.module_on |-> sck_oe_n == !c.master_role_enable)
      else $error("clock drive wrong for role");
   AST_SDO_RELEASE: assert property (st && c.serial_out_disable |-> serial_out_oe_n)
      else $error("data out not released");
   AST_SDO_DRIVE: assert property (st && c.module_on && c.master_role_enable && !c.serial_out_disable |-> !serial_out_oe_n)
      else $error("data out not driven");
   AST_SYNC_INPUT: assert property (st && c.module_on && c.framed_mode_enable && c.frame_sync_direction |-> select_pin_oe_n)
      else $error("sync pin driven as input");
   cover property (wr && paddr == SFA_OFS_CTRL);
   cover property (pready && pslverr);
   cover property (st && !sck_oe_n && !serial_out_oe_n);
endmodule

bind sfa_port sfa_port_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .sck_o(sck_o), .sck_oe_n(sck_oe_n),
   .serial_out_oe_n(serial_out_oe_n), .select_pin_oe_n(select_pin_oe_n));

//--- bench/sfa_partner.sv
// Behavioural serial slave device facing the port.
`timescale 1ns/1ps
module sfa_partner #(
   parameter logic [31:0] PAT = 32'hA5C3_6E19
) (
   input wire logic pclk,
   input wire logic clr,
   input wire logic sck,
   input wire logic sck_oe_n,
   input wire logic sdo,
   output logic sdi,
   output logic [31:0] got,
   output logic [5:0] nbits
);
   logic [5:0] lead_q = 6'h00;
   logic bit_q = 1'b0;
   logic tgl_q = 1'b0;
   // While the port releases its clock, the data line shows a changing level, never the last bit.
   always @(posedge pclk) tgl_q <= ~tgl_q;
   assign sdi = sck_oe_n ? tgl_q : bit_q;
   // New bit on the leading edge, with the clock idle low.
   always @(posedge sck or posedge clr) begin
      if (clr) begin
         lead_q <= 6'h00;
      end else begin
         bit_q <= PAT[5'd31 - lead_q[4:0]];
         lead_q <= lead_q + 6'h01;
      end
   end
   always @(negedge sck or posedge clr) begin
      if (clr) begin
         got <= 32'h0000_0000;
         nbits <= 6'h00;
      end else begin
         got <= {got[30:0], sdo};
         nbits <= nbits + 6'h01;
      end
   end
endmodule

//--- bench/sfa_port_bench.sv
// Self-checking bench for the serial port block.
`timescale 1ns/1ps
module sfa_port_bench
   import sfa_pkg::*;
;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic idle_mode = 1'b0, clr = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, got;
   logic [5:0] nbits;
   logic pready, pslverr, sck_o, sck_oe_n, sdi, sdo, sdo_oe_n, sel_o, sel_oe_n;
   int error_cnt = 0;
   int checks = 0;
   always #20 pclk = ~pclk;
   sfa_port uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .idle_mode(idle_mode), .reference_clock(1'b0), .sck_i(1'b0),
      .sck_o(sck_o), .sck_oe_n(sck_oe_n), .sdi_i(sdi), .serial_out_pin(sdo),
      .serial_out_oe_n(sdo_oe_n), .select_pin_i(1'b1), .select_pin_o(sel_o),
      .select_pin_oe_n(sel_oe_n));
   sfa_partner peer (.pclk(pclk), .clr(clr), .sck(sck_o), .sck_oe_n(sck_oe_n), .sdo(sdo),
      .sdi(sdi), .got(got), .nbits(nbits));
   // ---------------------------------------------------------------
   // Bus cycles and comparison
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         error_cnt++;
         $display("Error pready expected 1 seen %b", pready);
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] x);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
      apb(1'b0, a, 32'h0, r, e);
      chk("register", x, r);
   endtask
   task automatic word(input logic [31:0] c, input logic [31:0] d, input logic [5:0] w,
                       input logic [31:0] rx, input bit idl);
      int n;
      logic [31:0] r;
      logic e;
      apb(1'b1, SFA_OFS_CTRL, c, r, e);
      clr <= 1'b1; @(posedge pclk); clr <= 1'b0;
      idle_mode <= idl;
      apb(1'b1, SFA_OFS_DATA, d, r, e);
      if (idl) begin
         repeat (150) @(posedge pclk);
         chk("bits in idle", 32'h0, {26'h0, nbits});
         idle_mode <= 1'b0;
      end
      n = 0;
      while (nbits !== w && n < 3000) begin @(posedge pclk); n++; end
      repeat (20) @(posedge pclk);
      chk("bit count", {26'h0, w}, {26'h0, nbits});
      chk("sent word", d, got);
      apb(1'b0, SFA_OFS_STAT, 32'h0, r, e);
      chk("status", 32'h0000_0009, r);
      apb(1'b0, SFA_OFS_DATA, 32'h0, r, e);
      chk("received word", rx, r);
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_unmapped();
      logic [31:0] r;
      logic e;
      apb(1'b1, 8'h10, 32'hFFFF_FFFF, r, e);
      chk("write error", 32'h1, {31'h0, e});
      apb(1'b0, 8'h10, 32'h0, r, e);
      chk("read error data", 32'h0, r);
   endtask
   task automatic t_control();
      wr_rd(SFA_OFS_CTRL, 32'h0000_0000, 32'h0000_0000);
      wr_rd(SFA_OFS_CTRL, 32'hFDFF_FEFF, 32'hFD83_BCE0);
      wr_rd(SFA_OFS_CTRL, 32'h0000_0000, 32'h0081_0000);
      wr_rd(SFA_OFS_CTRL, 32'h0000_0020, 32'h0000_0020);
      wr_rd(SFA_OFS_CTRL, 32'h0000_0220, 32'h0000_0220);
      wr_rd(SFA_OFS_CTRL2, 32'h0000_0080, 32'h0000_0080);
      wr_rd(SFA_OFS_CTRL2, 32'h0000_0000, 32'h0000_0000);
   endtask
   task automatic tally_and_finish();
      if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      tally_and_finish();
   end
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_unmapped();
      t_control();
      word(32'h0000_8020, 32'h0000_00C3, 6'd8, 32'h0000_00A5, 1'b0);
      word(32'h0000_8420, 32'h0000_BEEF, 6'd16, 32'h0000_A5C3, 1'b0);
      word(32'h0000_8C20, 32'h1234_5678, 6'd32, 32'hA5C3_6E19, 1'b0);
      word(32'h0000_A020, 32'h0000_005A, 6'd8, 32'h0000_00A5, 1'b1);
      tally_and_finish();
   end
endmodule
